// ### rtl/wwd_top.sv
// register bank and control of the windowed watchdog
`timescale 1ns/10ps
`default_nettype none
module wwd_top
   import wwd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        porReset,
   input  wire wwd_req_s    busReq,
   output logic [31:0]      busRdata,
   output logic             busReady,
   input  wire logic        accessGuardLock,
   input  wire logic [7:0]  startControl,
   input  wire logic [7:0]  startSetup,
   input  wire logic [7:0]  startWarn,
   input  wire logic        startLoad,
   output logic             earlyWarnIrq,
   output logic             systemResetReq
);
   // control state
   logic       lock_q, lock_d;
   logic       winMode_q, winMode_d;
   logic       enable_q, enable_d;
   logic [7:0] setup_q, setup_d;
   logic [3:0] warn_q, warn_d;
   logic       irqMask_q, irqMask_d;
   logic       irqFlag_q, irqFlag_d;
   logic [1:0] syncCnt_q, syncCnt_d;
   logic       kick_q, kick_d;
   logic       badKick_q, badKick_d;
   logic       rstReq_q, rstReq_d;
   logic [31:0] rdata_q, rdata_d;
   logic       guardSync;
   logic       warnPulse, expire;
   wwd_cfg_s   cfg;

   // strap-like guard input comes from another domain
   wwd_sync wwd_sync_i (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (accessGuardLock),
      .dout     (guardSync)
   );

   // byte lane select for one register offset within the word
   function automatic logic laneHit(input wwd_req_s r, input logic [3:0] ofs);
      logic hit;
      hit = r.valid && r.write && (r.addr[3:2] == ofs[3:2]) && r.byteEn[ofs[1:0]];
      return hit;
   endfunction

   function automatic logic [7:0] laneData(input wwd_req_s r, input logic [3:0] ofs);
      logic [7:0] b;
      b = r.wdata[8*ofs[1:0] +: 8];
      return b;
   endfunction

   // engine settings; lock forces the watchdog on
   always_comb begin
      cfg.run        = enable_q || lock_q;
      cfg.winMode    = winMode_q;
      cfg.closedCode = setup_q[CLOSED_LSB +: 4];
      cfg.openCode   = setup_q[OPEN_LSB +: 4];
      cfg.warnCode   = warn_q;
   end

   wwd_counter wwd_counter_i (
      .core_clk  (core_clk),
      .reset     (reset),
      .cfg       (cfg),
      .kick      (kick_q),
      .badKick   (badKick_q),
      .warnPulse (warnPulse),
      .expire    (expire)
   );

   // register writes; each byte lane is decoded on its own byte-enable bit, so one access may write several registers
   always_comb begin
      logic [7:0] b;
      logic       running;
      b          = RST_BYTE;
      running    = enable_q || lock_q;
      lock_d     = lock_q;
      winMode_d  = winMode_q;
      enable_d   = enable_q;
      setup_d    = setup_q;
      warn_d     = warn_q;
      irqMask_d  = irqMask_q;
      irqFlag_d  = irqFlag_q;
      syncCnt_d  = (syncCnt_q != SYNC_ZERO) ? syncCnt_q - 2'h1 : SYNC_ZERO;
      kick_d     = 1'b0;
      badKick_d  = 1'b0;
      rstReq_d   = rstReq_q || expire;
      if (laneHit(busReq, OFS_CONTROL)) begin
         b = laneData(busReq, OFS_CONTROL);
         if (!lock_q) begin
            lock_d   = b[BIT_LOCK];
            enable_d = b[BIT_ENABLE];
            syncCnt_d = 2'h3;
         end
         if (!enable_q || lock_q) begin
            winMode_d = b[BIT_WINMODE];
         end
      end
      if (laneHit(busReq, OFS_SETUP) && !lock_q && !running) begin
         setup_d = laneData(busReq, OFS_SETUP);
      end
      if (laneHit(busReq, OFS_WARN) && !lock_q && !guardSync && !running) begin
         b = laneData(busReq, OFS_WARN);
         warn_d    = b[3:0];
         syncCnt_d = 2'h3;
      end
      // a function result cannot be bit-selected, so the lane is shifted and masked
      if (laneHit(busReq, OFS_MASK_CLR) &&
          ((laneData(busReq, OFS_MASK_CLR) >> BIT_EW) & 8'h01) != 8'h00) begin
         irqMask_d = 1'b0;
      end
      if (laneHit(busReq, OFS_MASK_SET) &&
          ((laneData(busReq, OFS_MASK_SET) >> BIT_EW) & 8'h01) != 8'h00) begin
         irqMask_d = 1'b1;
      end
      if (laneHit(busReq, OFS_PENDING) &&
          ((laneData(busReq, OFS_PENDING) >> BIT_EW) & 8'h01) != 8'h00) begin
         irqFlag_d = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (warnPulse) begin
         irqFlag_d = 1'b1;
      end
      if (laneHit(busReq, OFS_KICK) && running) begin
         if (laneData(busReq, OFS_KICK) == KICK_KEY_VAL) begin
            kick_d = 1'b1;
         end else begin
            badKick_d = 1'b1;
            rstReq_d  = 1'b1;
         end
      end
      // startup configuration load overrides the control, setup and warning register writes
      if (startLoad) begin
         lock_d    = startControl[BIT_LOCK];
         winMode_d = startControl[BIT_WINMODE];
         enable_d  = startControl[BIT_ENABLE];
         setup_d   = startSetup;
         warn_d    = startWarn[3:0];
      end
   end

   // read mux; reserved bits and the write-only kick read as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (busReq.valid && !busReq.write) begin
         case (busReq.addr[3:2])
            2'h0: begin
               rdata_d[7:0]   = {lock_q, 4'h0, winMode_q, enable_q, 1'b0};
               rdata_d[15:8]  = setup_q;
               rdata_d[23:16] = {4'h0, warn_q};
            end
            2'h1: begin
               rdata_d[7:0]   = {7'h00, irqMask_q};
               rdata_d[15:8]  = {7'h00, irqMask_q};
               rdata_d[23:16] = {7'h00, irqFlag_q};
               rdata_d[31:24] = {(syncCnt_q != SYNC_ZERO), 7'h00};
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // lock clears only on power-on reset or a startup load with the lock bit clear
   always_ff @(posedge core_clk or posedge porReset) begin
      if (porReset) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_d || lock_q && !startLoad;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         winMode_q <= 1'b0;
         enable_q  <= 1'b0;
         setup_q   <= RST_BYTE;
         warn_q    <= 4'h0;
         irqMask_q <= 1'b0;
         irqFlag_q <= 1'b0;
         syncCnt_q <= SYNC_ZERO;
         kick_q    <= 1'b0;
         badKick_q <= 1'b0;
         rstReq_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
      end else begin
         winMode_q <= winMode_d;
         enable_q  <= enable_d;
         setup_q   <= setup_d;
         warn_q    <= warn_d;
         irqMask_q <= irqMask_d;
         irqFlag_q <= irqFlag_d;
         syncCnt_q <= syncCnt_d;
         kick_q    <= kick_d;
         badKick_q <= badKick_d;
         rstReq_q  <= rstReq_d;
         rdata_q   <= rdata_d;
      end
   end

   assign busRdata       = rdata_q;
   assign busReady       = 1'b1;
   assign earlyWarnIrq   = irqFlag_q && irqMask_q;
   assign systemResetReq = rstReq_q;
endmodule // wwd_top

`default_nettype wire

// ### common/wwd_pkg.sv
// package: register map, field layout, reset values and types of the windowed watchdog
package wwd_pkg;
   // register offsets (byte addresses inside the block)
   localparam logic [3:0] OFS_CONTROL    = 4'h0;
   localparam logic [3:0] OFS_SETUP      = 4'h1;
   localparam logic [3:0] OFS_WARN       = 4'h2;
   localparam logic [3:0] OFS_GAP        = 4'h3;
   localparam logic [3:0] OFS_MASK_CLR   = 4'h4;
   localparam logic [3:0] OFS_MASK_SET   = 4'h5;
   localparam logic [3:0] OFS_PENDING    = 4'h6;
   localparam logic [3:0] OFS_STATE      = 4'h7;
   localparam logic [3:0] OFS_KICK       = 4'h8;
   // field positions
   localparam int BIT_LOCK     = 7;
   localparam int BIT_WINMODE  = 2;
   localparam int BIT_ENABLE   = 1;
   localparam int BIT_EW       = 0;
   localparam int BIT_BUSY     = 7;
   localparam int CLOSED_LSB   = 4;
   localparam int OPEN_LSB     = 0;
   // values
   localparam logic [7:0] KICK_KEY_VAL  = 8'ha5;
   localparam logic [3:0] CODE_MAX      = 4'hb;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam int         CNT_W         = 16;
   localparam logic [CNT_W-1:0] BASE_LEN = 16'h0008;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [1:0] SYNC_ZERO     = 2'h0;

   // bus access from the peripheral side
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [3:0] addr;
      logic [3:0] byteEn;
      logic [31:0] wdata;
   } wwd_req_s;

   // settings carried into the counting domain
   typedef struct packed {
      logic       run;
      logic       winMode;
      logic [3:0] closedCode;
      logic [3:0] openCode;
      logic [3:0] warnCode;
   } wwd_cfg_s;

   typedef enum logic [1:0] {ST_IDLE, ST_CLOSED, ST_OPEN} wwd_phase_e;

   // doubling encoding: 8 << code; reserved codes saturate at the top length
   function automatic logic [CNT_W-1:0] codeLen(input logic [3:0] code);
      logic [3:0] c;
      c = (code > CODE_MAX) ? CODE_MAX : code;
      return BASE_LEN << c;
   endfunction
endpackage

// ### rtl/wwd_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module wwd_sync (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic din,
   output logic      dout
);
   logic [1:0] stage_q;
   logic [1:0] stage_d;

   // first stage only feeds the second
   always_comb begin
      stage_d = {stage_q[0], din};
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         stage_q <= 2'h0;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign dout = stage_q[1];
endmodule // wwd_sync

`default_nettype wire

// ### rtl/wwd_counter.sv
// counting engine: closed and open phases and the early warning of the watchdog
`timescale 1ns/10ps
`default_nettype none
module wwd_counter
   import wwd_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     reset,
   input  wire wwd_cfg_s cfg,
   input  wire logic     kick,
   input  wire logic     badKick,
   output logic          warnPulse,
   output logic          expire
);
   wwd_phase_e       phase_q, phase_d;
   logic [CNT_W-1:0] count_q, count_d;
   logic             warned_q, warned_d;
   logic [CNT_W-1:0] closedLen, openLen, warnLen;

   assign closedLen = codeLen(cfg.closedCode);
   assign openLen   = codeLen(cfg.openCode);
   assign warnLen   = codeLen(cfg.warnCode);

   // phase sequencer; counter restarts on start and on a valid kick in the open phase
   always_comb begin
      phase_d   = phase_q;
      count_d   = count_q;
      warned_d  = warned_q;
      warnPulse = 1'b0;
      expire    = 1'b0;
      case (phase_q)
         ST_IDLE: begin
            count_d  = CNT_ZERO;
            warned_d = 1'b0;
            if (cfg.run) begin
               phase_d = cfg.winMode ? ST_CLOSED : ST_OPEN;
            end
         end
         ST_CLOSED: begin
            count_d = count_q + 16'h0001;
            if (!cfg.run) begin
               phase_d = ST_IDLE;
            end else if (kick || badKick) begin
               expire = 1'b1;
               phase_d = ST_IDLE;
            end else if (count_d >= closedLen) begin
               phase_d   = ST_OPEN;
               count_d   = CNT_ZERO;
               warnPulse = 1'b1;
               warned_d  = 1'b1;
            end
         end
         ST_OPEN: begin
            count_d = count_q + 16'h0001;
            if (!cfg.run) begin
               phase_d = ST_IDLE;
            end else if (badKick) begin
               expire  = 1'b1;
               phase_d = ST_IDLE;
            end else if (kick) begin
               count_d  = CNT_ZERO;
               warned_d = 1'b0;
               phase_d  = cfg.winMode ? ST_CLOSED : ST_OPEN;
            end else if (count_d >= openLen) begin
               expire  = 1'b1;
               phase_d = ST_IDLE;
            end else if (!cfg.winMode && !warned_q && count_d >= warnLen) begin
               warnPulse = 1'b1;
               warned_d  = 1'b1;
            end
         end
         default: phase_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         phase_q  <= ST_IDLE;
         count_q  <= CNT_ZERO;
         warned_q <= 1'b0;
      end else begin
         phase_q  <= phase_d;
         count_q  <= count_d;
         warned_q <= warned_d;
      end
   end
endmodule // wwd_counter

`default_nettype wire

// ### tb/wwd_monitor.sv
// checker: bus, reserved-bit, lock and reset-request relations of the watchdog bank
`timescale 1ns/10ps
`default_nettype none
module wwd_monitor
   import wwd_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        porReset,
   input wire wwd_req_s    busReq,
   input wire logic [31:0] busRdata,
   input wire logic        busReady,
   input wire logic        accessGuardLock,
   input wire logic [7:0]  startControl,
   input wire logic [7:0]  startSetup,
   input wire logic [7:0]  startWarn,
   input wire logic        startLoad,
   input wire logic        earlyWarnIrq,
   input wire logic        systemResetReq
);
   logic        rdWord0, rdWord1, maskClr;
   logic        rd0_q, rd0_d, lockSeen_q, lockSeen_d;
   logic [23:0] snap_q, snap_d;
   // request decode
   assign rdWord0 = busReq.valid && !busReq.write && busReq.addr[3:2] == 2'h0;
   assign rdWord1 = busReq.valid && !busReq.write && busReq.addr[3:2] == 2'h1;
   assign maskClr = busReq.valid && busReq.write && busReq.addr[3:2] == 2'h1
                    && busReq.byteEn[1:0] == 2'h1 && busReq.wdata[0];
   // first locked read is kept; only window mode may move after it
   always_comb begin
      rd0_d = rdWord0;
      lockSeen_d = lockSeen_q;
      snap_d = snap_q;
      if (rd0_q && busRdata[7] && !lockSeen_q) begin
         lockSeen_d = 1'b1;
         snap_d = busRdata[23:0];
      end
   end
   // helper registers, cleared with either reset since reset may clear the bank
   always_ff @(posedge core_clk or posedge reset or posedge porReset) begin
      if (reset || porReset) begin
         rd0_q <= 1'b0;
         lockSeen_q <= 1'b0;
         snap_q <= 24'h0;
      end else begin
         rd0_q <= rd0_d;
         lockSeen_q <= lockSeen_d;
         snap_q <= snap_d;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset || porReset);
   a_ready_high: assert property (busReady)
      else $error("bus not ready");
   a_rdata_idle: assert property (!$past(busReq.valid && !busReq.write) |-> busRdata == 32'h0)
      else $error("read data without a read");
   a_word0_rsvd: assert property ($past(rdWord0) |-> (busRdata & 32'hfff0_0079) == 32'h0)
      else $error("reserved bits set in word 0");
   a_word1_rsvd: assert property ($past(rdWord1) |-> (busRdata & 32'h7ffe_fefe) == 32'h0)
      else $error("reserved bits set in word 1");
   a_lock_frozen: assert property (rd0_q && lockSeen_q |->
      ((busRdata ^ {8'h00, snap_q}) & 32'h00ff_fffb) == 32'h0)
      else $error("locked settings changed");
   a_reset_sticky: assert property (systemResetReq |=> systemResetReq)
      else $error("reset request dropped");
   a_mask_clear: assert property (maskClr |=> !earlyWarnIrq)
      else $error("interrupt after mask clear");
   a_quiet_release: assert property ($fell(reset) |-> !systemResetReq && !earlyWarnIrq)
      else $error("outputs active after reset");
endmodule // wwd_monitor
`default_nettype wire

// ### tb/wwd_top_bench.sv
// self-checking bench for the watchdog register bank
`timescale 1ns/10ps
`default_nettype none
module wwd_top_bench import wwd_pkg::*;;
   logic        core_clk, reset, porReset, accessGuardLock, startLoad;
   logic        busReady, earlyWarnIrq, systemResetReq;
   logic [7:0]  startControl, startSetup, startWarn;
   logic [31:0] busRdata;
   wwd_req_s    busReq;
   int          badCount = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n;
   wwd_top wwd_top_i (.core_clk(core_clk), .reset(reset), .porReset(porReset),
      .busReq(busReq), .busRdata(busRdata), .busReady(busReady),
      .accessGuardLock(accessGuardLock), .startControl(startControl),
      .startSetup(startSetup), .startWarn(startWarn), .startLoad(startLoad),
      .earlyWarnIrq(earlyWarnIrq), .systemResetReq(systemResetReq));
   // 200 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // hang guard, far above the longest expected run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         wrapUp();
      end
   end
   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
      comparisons++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
      end
   endtask
   // one-cycle write; an idle edge first so valid is never driven twice in one step
   task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge core_clk);
      busReq = '{1'b1, 1'b1, a, be, d};
      @(negedge core_clk);
      busReq.valid = 1'b0;
   endtask
   // data is registered at the taking edge, so it is looked at on the next falling edge
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string w);
      @(negedge core_clk);
      busReq = '{1'b1, 1'b0, a, 4'hf, 32'h0};
      @(negedge core_clk);
      check(busRdata & m, e, w);
      busReq.valid = 1'b0;
   endtask
   task automatic init(input logic por, input logic ld, input logic [7:0] c, s, w);
      reset = 1'b1;
      porReset = por;
      repeat (6) @(negedge core_clk);
      {reset, porReset, startControl, startSetup, startWarn, startLoad} = {2'b0, c, s, w, ld};
      @(negedge core_clk);
      startLoad = 1'b0;
   endtask
   // bounded wait for the reset request
   task automatic waitReset(input int lim, input string w);
      for (n = 0; n < lim && systemResetReq !== 1'b1; n++) @(negedge core_clk);
      check({31'h0, systemResetReq}, 32'h1, w);
   endtask
   initial begin
      busReq = '0;
      {accessGuardLock, startLoad, startControl, startSetup, startWarn} = '0;
      init(1'b1, 1'b1, 8'h00, 8'h21, 8'h01);
      rd(4'h0, 32'hffff_ffff, 32'h0001_2100, "startup load");
      // normal mode: open 32, warning 16; room left for the kick before expiry
      wr(4'h0, 4'h7, 32'h0001_0202);
      rd(4'h4, 32'h8000_0000, 32'h8000_0000, "busy after enable");
      rd(4'h0, 32'h0000_00ff, 32'h0000_0002, "enable readback");
      wr(4'h4, 4'h2, 32'h0000_0100);
      for (n = 0; n < 40 && earlyWarnIrq !== 1'b1; n++) @(negedge core_clk);
      check({earlyWarnIrq, systemResetReq}, 32'h2, "warning before expiry");
      wr(4'h4, 4'h1, 32'h0000_0001);
      check({31'h0, earlyWarnIrq}, 32'h0, "mask clear");
      wr(4'h4, 4'h4, 32'h0001_0000);
      wr(4'h4, 4'h2, 32'h0000_0100);
      check({31'h0, earlyWarnIrq}, 32'h0, "flag clear");
      wr(4'h8, 4'h1, 32'h0000_00a5);
      repeat (12) @(negedge core_clk);
      check({31'h0, systemResetReq}, 32'h0, "kick restarts period");
      waitReset(40, "expiry reset");
      // window bit guarded while enabled and unlocked, free when stopped
      init(1'b1, 1'b1, 8'h02, 8'h0b, 8'h00);
      wr(4'h0, 4'h1, 32'h0000_0006);
      rd(4'h0, 32'h0000_00ff, 32'h0000_0002, "window bit guarded");
      wr(4'h0, 4'h1, 32'h0000_0000);
      rd(4'h0, 32'h0000_00ff, 32'h0000_0000, "disable");
      wr(4'h0, 4'h1, 32'h0000_0004);
      rd(4'h0, 32'h0000_00ff, 32'h0000_0004, "window bit set");
      // kick inside the closed window
      init(1'b1, 1'b1, 8'h06, 8'h30, 8'h00);
      repeat (4) @(negedge core_clk);
      wr(4'h8, 4'h1, 32'h0000_00a5);
      waitReset(10, "closed window kick");
      // window warning at open start (16), not at offset 8
      init(1'b1, 1'b1, 8'h06, 8'h12, 8'h00);
      wr(4'h4, 4'h2, 32'h0000_0100);
      for (n = 0; n < 60 && earlyWarnIrq !== 1'b1; n++) @(negedge core_clk);
      check({31'h0, n >= 12 && n <= 24}, 32'h1, "window warning time");
      wr(4'h8, 4'h1, 32'h0000_00a5);
      repeat (20) @(negedge core_clk);
      check({31'h0, systemResetReq}, 32'h0, "open window kick");
      wr(4'h8, 4'h1, 32'h0000_005a);
      waitReset(8, "wrong key");
      // lock freezes settings except the window bit and keeps the timer running
      init(1'b1, 1'b1, 8'h80, 8'h21, 8'h01);
      wr(4'h0, 4'h7, 32'h0000_0000);
      rd(4'h0, 32'hffff_ffff, 32'h0001_2180, "locked write ignored");
      wr(4'h0, 4'h1, 32'h0000_0084);
      rd(4'h0, 32'h0000_00ff, 32'h0000_0084, "window bit under lock");
      waitReset(80, "locked timer runs");
      init(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      rd(4'h0, 32'h0000_0080, 32'h0000_0080, "lock kept over reset");
      init(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
      rd(4'h0, 32'h0000_0080, 32'h0000_0000, "lock cleared at power on");
      // access guard on the warning offset
      init(1'b1, 1'b1, 8'h00, 8'h00, 8'h01);
      accessGuardLock = 1'b1;
      repeat (3) @(negedge core_clk);
      wr(4'h0, 4'h4, 32'h0005_0000);
      rd(4'h0, 32'h00ff_0000, 32'h0001_0000, "guarded offset");
      accessGuardLock = 1'b0;
      repeat (3) @(negedge core_clk);
      wr(4'h0, 4'h4, 32'h0005_0000);
      rd(4'h4, 32'h8000_0000, 32'h8000_0000, "offset sync busy");
      rd(4'h0, 32'h00ff_0000, 32'h0005_0000, "offset written");
      wrapUp();
   end
endmodule // wwd_top_bench
bind wwd_top wwd_monitor wwd_monitor_i (.core_clk(core_clk), .reset(reset),
   .porReset(porReset), .busReq(busReq), .busRdata(busRdata), .busReady(busReady),
   .accessGuardLock(accessGuardLock), .startControl(startControl),
   .startSetup(startSetup), .startWarn(startWarn), .startLoad(startLoad),
   .earlyWarnIrq(earlyWarnIrq), .systemResetReq(systemResetReq));
`default_nettype wire
